/* File: rtl/pdao_top.v */
// Deviation, alarm and over-torque outputs with Wishbone registers and interrupt.
// Assumes one 25 MHz clock; fault and trip inputs come from other clock
// domains or pins and are synchronised here; PID and torque values are
// synchronous samples from logic on the same clock.
`timescale 1ns/1ns
`include "pdao_regs.vh"
module pdao_top
#(
	parameter integer WIDTH = 16,
	parameter integer ALM_DLY_CYC = `PDAO_ALM_DLY_CYC,
	parameter integer PWRUP_CYC = `PDAO_PWRUP_CYC
)
(
	input wire i_ref_clk, // Reference clock
	input wire i_srst, // Synchronous reset, high
	// Wishbone slave
	input wire i_wb_cyc, // Cycle
	input wire i_wb_stb, // Strobe
	input wire i_wb_we, // Write enable
	input wire [7:0] i_wb_adr, // Byte address
	input wire [3:0] i_wb_sel, // Byte lanes
	input wire [31:0] i_wb_dat, // Write data
	output reg [31:0] o_wb_dat, // Read data
	output wire o_wb_ack, // Acknowledge
	// Process samples
	input wire [WIDTH-1:0] i_setpoint, // PID target
	input wire [WIDTH-1:0] i_process, // PID measured value
	input wire [WIDTH-1:0] i_torque, // Estimated torque
	// Fault status from the drive, asynchronous
	input wire i_fault, // Fault present
	input wire i_trip, // Drive in trip mode
	// Outputs
	output reg o_pid_error_excess_flag, // Deviation flag
	output reg o_fault_trip_flag, // Alarm flag, delayed
	output reg o_torque_excess_flag, // Over-torque flag
	output reg o_oc1_n, // Open-collector output 1, low on
	output reg o_oc2_n, // Open-collector output 2, low on
	output reg o_relay_coil, // Relay coil energized
	output reg o_irq // Interrupt, level
);

// ==========================================================
// Registers
reg pol_q; // Relay polarity, 0 closed, 1 open
reg [WIDTH-1:0] devlvl_q; // deviation_level_setting
reg [WIDTH-1:0] trqlvl_q; // Torque level
reg [7:0] rt_o1_q; // Option code on output 1
reg [7:0] rt_o2_q; // Option code on output 2
reg [7:0] rt_rly_q; // Option code on relay
reg [3:0] ist_q; // Sticky events
reg [3:0] imsk_q; // Event mask
reg ack_q; // Bus acknowledge
reg alm_latch_q; // Alarm held until clear
reg clr_pulse_q; // Software alarm clear
reg [31:0] pwr_cnt_q; // Power-up settle count
reg ready_q; // Settle interval passed
reg dev_prev_q; // Edge detect deviation
reg alm_prev_q; // Edge detect alarm
reg trq_prev_q; // Edge detect torque
reg flt_prev_q; // Edge detect raw fault

// Two-stage synchronisers; stage one read only by stage two
reg flt_s1_q;
reg flt_s2_q;
reg trp_s1_q;
reg trp_s2_q;

wire dev_w; // Deviation flag from comparator
wire alm_raw_w; // Undelayed alarm
wire alm_dly_w; // Delayed alarm
wire req_w = i_wb_cyc & i_wb_stb & ~ack_q;
wire wr_w = i_wb_cyc & i_wb_stb & i_wb_we & ack_q; // Lands at the edge ack is seen
wire [3:0] ev_w; // Rising events this cycle

// Select the level chosen by an option code
function route_sel;
	input [7:0] code;
	input dev;
	input alm;
	input trq;
	begin
		case (code)
			`PDAO_OPT_DEV: route_sel = dev; // see RULE4
			`PDAO_OPT_ALM: route_sel = alm; // see RULE8
			8'h07: route_sel = trq;
			default: route_sel = 1'b0;
		endcase
	end
endfunction

// Byte-lane merge of a write into a 32-bit word
function [31:0] lane_merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] sel;
	integer k;
	begin
		lane_merge = old;
		for (k = 0; k < 4; k = k + 1)
		begin
			if (sel[k])
			begin
				lane_merge[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
	end
endfunction

// Register words with a write merged in, lane by lane
wire [31:0] devlvl_mrg_w = lane_merge({{(32-WIDTH){1'b0}}, devlvl_q}, i_wb_dat, i_wb_sel);
wire [31:0] trqlvl_mrg_w = lane_merge({{(32-WIDTH){1'b0}}, trqlvl_q}, i_wb_dat, i_wb_sel);
wire [31:0] route_mrg_w = lane_merge({8'h00, rt_rly_q, rt_o2_q, rt_o1_q}, i_wb_dat, i_wb_sel);

// ==========================================================
// Synchronise the drive fault and trip levels
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		flt_s1_q <= 1'b0;
		flt_s2_q <= 1'b0;
		trp_s1_q <= 1'b0;
		trp_s2_q <= 1'b0;
	end
	else
	begin
		flt_s1_q <= i_fault;
		flt_s2_q <= flt_s1_q;
		trp_s1_q <= i_trip;
		trp_s2_q <= trp_s1_q;
	end
end

// ==========================================================
// Deviation comparison
pdao_compare #(
	.WIDTH(WIDTH)
) u_cmp (
	.i_ref_clk(i_ref_clk),
	.i_srst(i_srst),
	.i_setpoint(i_setpoint),
	.i_process(i_process),
	.i_level(devlvl_q),
	.o_error(),
	.o_flag(dev_w)
);

// ==========================================================
// Alarm latch: set while fault and trip mode both stand, held until fault gone
// or a clear is written; set wins over clear in the same cycle
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		alm_latch_q <= 1'b0;
		flt_prev_q <= 1'b0;
	end
	else
	begin
		flt_prev_q <= flt_s2_q;
		if (flt_s2_q & trp_s2_q)
		begin
			alm_latch_q <= 1'b1; // see RULE6
		end
		else if (clr_pulse_q | ~flt_s2_q)
		begin
			// Fault gone or clear written: inactive until fault and trip mode again, see RULE7
			alm_latch_q <= 1'b0; // see RULE15
		end
	end
end

assign alm_raw_w = alm_latch_q;

// Nominal output delay behind the fault indication
pdao_delay #(
	.DELAY_CYC(ALM_DLY_CYC)
) u_dly (
	.i_ref_clk(i_ref_clk),
	.i_srst(i_srst),
	.i_level(alm_raw_w),
	.o_level(alm_dly_w)
);

// ==========================================================
// Power-up settle before a normally closed relay may energize
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		pwr_cnt_q <= 32'h0000_0000;
		ready_q <= 1'b0;
	end
	else if (!ready_q)
	begin
		if (pwr_cnt_q >= PWRUP_CYC - 1)
		begin
			ready_q <= 1'b1; // see RULE11
		end
		else
		begin
			pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
		end
	end
end

// ==========================================================
// Output stage; open-collector pins are active low
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		o_pid_error_excess_flag <= 1'b0;
		o_fault_trip_flag <= 1'b0;
		o_torque_excess_flag <= 1'b0;
		o_oc1_n <= 1'b1;
		o_oc2_n <= 1'b1;
		o_relay_coil <= 1'b0;
	end
	else
	begin
		o_pid_error_excess_flag <= dev_w;
		o_fault_trip_flag <= alm_dly_w;
		o_torque_excess_flag <= (i_torque > trqlvl_q); // see RULE14
		o_oc1_n <= ~route_sel(rt_o1_q, dev_w, alm_dly_w, o_torque_excess_flag);
		o_oc2_n <= ~route_sel(rt_o2_q, dev_w, alm_dly_w, o_torque_excess_flag);
		if (rt_rly_q == `PDAO_OPT_ALM && pol_q == `PDAO_POL_NC)
		begin
			// Closed: coil held while healthy, dropped on trip, see RULE12
			o_relay_coil <= ready_q & ~alm_dly_w; // see RULE11
		end
		else if (rt_rly_q == `PDAO_OPT_ALM)
		begin
			// Open: coil only while the trip stands
			o_relay_coil <= alm_dly_w; // see RULE13
		end
		else
		begin
			o_relay_coil <= ready_q & route_sel(rt_rly_q, dev_w, alm_dly_w,
				o_torque_excess_flag);
		end
	end
end

// ==========================================================
// Interrupt events: rising edges of each flag and of the raw fault
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		dev_prev_q <= 1'b0;
		alm_prev_q <= 1'b0;
		trq_prev_q <= 1'b0;
	end
	else
	begin
		dev_prev_q <= dev_w;
		alm_prev_q <= alm_dly_w;
		trq_prev_q <= o_torque_excess_flag;
	end
end

assign ev_w = {flt_s2_q & ~flt_prev_q, o_torque_excess_flag & ~trq_prev_q,
	alm_dly_w & ~alm_prev_q, dev_w & ~dev_prev_q};

// ==========================================================
// Register writes, sticky status and one-cycle acknowledge
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		ack_q <= 1'b0;
		pol_q <= `PDAO_POL_NC; // see RULE10
		devlvl_q <= `PDAO_DEVLVL_RST; // see RULE5
		trqlvl_q <= `PDAO_TRQLVL_RST;
		{rt_rly_q, rt_o2_q, rt_o1_q} <= `PDAO_ROUTE_RST;
		ist_q <= 4'h0;
		imsk_q <= 4'h0;
		clr_pulse_q <= 1'b0;
	end
	else
	begin
		ack_q <= req_w;
		clr_pulse_q <= 1'b0;
		// Write one to clear; a new event in the same cycle stays set
		ist_q <= (ist_q & ~((wr_w && i_wb_adr == `PDAO_IRQ_STAT_OFS && i_wb_sel[0])
			? i_wb_dat[3:0] : 4'h0)) | ev_w;
		if (wr_w)
		begin
			case (i_wb_adr)
				`PDAO_CTRL_OFS:
				begin
					if (i_wb_sel[0])
					begin
						pol_q <= i_wb_dat[`PDAO_CTRL_POL_BIT];
						clr_pulse_q <= i_wb_dat[`PDAO_CTRL_CLR_BIT];
					end
				end
				`PDAO_DEVLVL_OFS: devlvl_q <= devlvl_mrg_w[WIDTH-1:0];
				`PDAO_TRQLVL_OFS: trqlvl_q <= trqlvl_mrg_w[WIDTH-1:0];
				`PDAO_ROUTE_OFS: {rt_rly_q, rt_o2_q, rt_o1_q} <= route_mrg_w[23:0];
				`PDAO_IRQ_MASK_OFS:
				begin
					if (i_wb_sel[0])
					begin
						imsk_q <= i_wb_dat[3:0];
					end
				end
				default:
				begin
					// Unmapped or read-only: acknowledged and ignored
				end
			endcase
		end
	end
end

assign o_wb_ack = ack_q;

// ==========================================================
// Read data registered with the request; unmapped reads return zero
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		o_wb_dat <= 32'h0000_0000;
		o_irq <= 1'b0;
	end
	else
	begin
		o_irq <= |(ist_q & imsk_q);
		if (req_w && !i_wb_we)
		begin
			case (i_wb_adr)
				`PDAO_CTRL_OFS: o_wb_dat <= {31'h0000_0000, pol_q};
				`PDAO_DEVLVL_OFS: o_wb_dat <= {{(32-WIDTH){1'b0}}, devlvl_q};
				`PDAO_TRQLVL_OFS: o_wb_dat <= {{(32-WIDTH){1'b0}}, trqlvl_q};
				`PDAO_ROUTE_OFS: o_wb_dat <= {8'h00, rt_rly_q, rt_o2_q, rt_o1_q};
				`PDAO_STAT_OFS: o_wb_dat <= {27'h000_0000, ready_q, o_relay_coil,
					o_torque_excess_flag, o_fault_trip_flag, o_pid_error_excess_flag};
				`PDAO_IRQ_STAT_OFS: o_wb_dat <= {28'h000_0000, ist_q};
				`PDAO_IRQ_MASK_OFS: o_wb_dat <= {28'h000_0000, imsk_q};
				default: o_wb_dat <= 32'h0000_0000;
			endcase
		end
	end
end

endmodule

/* File: rtl/pdao_regs.vh */
// Constants of the deviation, alarm and torque output block: offsets, fields, resets, timing.
// Assumes a 25 MHz reference clock and a 32-bit classic Wishbone register port.
// Notes on behaviour
// RULE1: error is absolute setpoint minus process value
// RULE2: deviation flag on when error exceeds level
// RULE3: deviation flag off when error below level
// RULE4: deviation function selected by option code 04
// RULE5: deviation level resets to three percent
// RULE6: alarm on while fault and trip mode
// RULE7: alarm off once fault cleared until next
// RULE8: alarm is code 05, routable to any output
// RULE9: alarm follows fault after about 300 ms
// RULE10: relay polarity resets to normally closed, 0
// RULE11: closed mode energizes relay within 2 s
// RULE12: closed mode de-energizes relay on trip
// RULE13: open mode energizes relay only on trip
// RULE14: torque flag on when torque exceeds level
// RULE15: alarm off when no fault since clear
// RULE16: error equal to level keeps deviation flag
`ifndef PDAO_REGS_VH
`define PDAO_REGS_VH

// ==========================================================
// Register byte offsets
`define PDAO_CTRL_OFS 8'h00
`define PDAO_DEVLVL_OFS 8'h04
`define PDAO_TRQLVL_OFS 8'h08
`define PDAO_ROUTE_OFS 8'h0C
`define PDAO_STAT_OFS 8'h10
`define PDAO_IRQ_STAT_OFS 8'h14
`define PDAO_IRQ_MASK_OFS 8'h18

// ==========================================================
// Field positions
`define PDAO_CTRL_POL_BIT 0
`define PDAO_CTRL_CLR_BIT 1
`define PDAO_ROUTE_O1_LSB 0
`define PDAO_ROUTE_O2_LSB 8
`define PDAO_ROUTE_RLY_LSB 16
`define PDAO_ST_DEV_BIT 0
`define PDAO_ST_ALM_BIT 1
`define PDAO_ST_TRQ_BIT 2
`define PDAO_ST_RLY_BIT 3
`define PDAO_ST_RDY_BIT 4

// ==========================================================
// Option codes and reset values
`define PDAO_OPT_DEV 8'h04
`define PDAO_OPT_ALM 8'h05
`define PDAO_POL_NC 1'b0
`define PDAO_DEVLVL_RST 16'h0003
`define PDAO_TRQLVL_RST 16'h0064
`define PDAO_ROUTE_RST 24'h05_0504

// ==========================================================
// Timing in its own units, counts derived from the clock rate
`define PDAO_CLK_HZ 25000000
`define PDAO_ALM_DLY_MS 300
`define PDAO_PWRUP_MS 1000
`define PDAO_ALM_DLY_CYC (`PDAO_CLK_HZ / 1000 * `PDAO_ALM_DLY_MS)
`define PDAO_PWRUP_CYC (`PDAO_CLK_HZ / 1000 * `PDAO_PWRUP_MS)

`endif

/* File: rtl/pdao_delay.v */
// Delay line for a single level: output follows input after a fixed hold time.
// Assumes a synchronous input on the same clock; the count is a parameter.
`timescale 1ns/1ns
module pdao_delay
#(
	parameter integer DELAY_CYC = 7500000
)
(
	input wire i_ref_clk, // Reference clock
	input wire i_srst, // Synchronous reset, high
	input wire i_level, // Level to delay
	output reg o_level // Delayed level
);

// Cycles the input has differed from the output
reg [31:0] cnt_q;

// ==========================================================
// Output changes only once the input has held its new value long enough,
// so a glitch shorter than the delay never reaches the output
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		cnt_q <= 32'h0000_0000;
		o_level <= 1'b0;
	end
	else if (i_level == o_level)
	begin
		cnt_q <= 32'h0000_0000;
	end
	else if (cnt_q >= DELAY_CYC - 1)
	begin
		// Hold time reached
		cnt_q <= 32'h0000_0000;
		o_level <= i_level; // see RULE9
	end
	else
	begin
		cnt_q <= cnt_q + 32'h0000_0001;
	end
end

endmodule

/* File: rtl/pdao_compare.v */
// Magnitude and threshold comparison for the PID deviation flag.
// Assumes setpoint and process value are unsigned samples in the same clock.
`timescale 1ns/1ns
module pdao_compare
#(
	parameter integer WIDTH = 16
)
(
	input wire i_ref_clk, // Reference clock
	input wire i_srst, // Synchronous reset, high
	input wire [WIDTH-1:0] i_setpoint, // Target value
	input wire [WIDTH-1:0] i_process, // Measured value
	input wire [WIDTH-1:0] i_level, // Deviation level
	output reg [WIDTH-1:0] o_error, // Error magnitude
	output reg o_flag // Deviation flag
);

// Absolute difference of two unsigned values
function [WIDTH-1:0] abs_diff;
	input [WIDTH-1:0] a;
	input [WIDTH-1:0] b;
	begin
		abs_diff = (a > b) ? (a - b) : (b - a);
	end
endfunction

wire [WIDTH-1:0] err_w = abs_diff(i_setpoint, i_process); // see RULE1

// ==========================================================
// Flag with a dead band of one point: equal leaves it alone
always @(posedge i_ref_clk)
begin
	if (i_srst)
	begin
		o_error <= {WIDTH{1'b0}};
		o_flag <= 1'b0;
	end
	else
	begin
		o_error <= err_w;
		if (err_w > i_level)
		begin
			o_flag <= 1'b1; // see RULE2
		end
		else if (err_w < i_level)
		begin
			o_flag <= 1'b0; // see RULE3
		end
		// Equal: previous state kept, see RULE16
	end
end

endmodule

/* File: tb/pdao_checker.sv */
// Checker of the deviation, alarm, torque and relay outputs at the top ports.
// Assumes full-lane register writes and the reset route of the relay.
`timescale 1ns/1ns
`include "pdao_regs.vh"
module pdao_checker
#(
	parameter int WIDTH = 16,
	parameter int ALM_DLY_CYC = 10,
	parameter int PWRUP_CYC = 20
)
(
	input wire i_ref_clk, // Clock
	input wire i_srst, // Reset
	input wire i_wb_cyc, // Cycle
	input wire i_wb_stb, // Strobe
	input wire i_wb_we, // Write
	input wire [7:0] i_wb_adr, // Address
	input wire [31:0] i_wb_dat, // Write data
	input wire o_wb_ack, // Acknowledge
	input wire [WIDTH-1:0] i_setpoint, // Target
	input wire [WIDTH-1:0] i_process, // Measured
	input wire [WIDTH-1:0] i_torque, // Torque
	input wire i_fault, // Fault
	input wire i_trip, // Trip
	input wire o_pid_error_excess_flag, // Deviation
	input wire o_fault_trip_flag, // Alarm
	input wire o_torque_excess_flag, // Torque
	input wire o_relay_coil // Coil
);
	localparam int AHI = ALM_DLY_CYC + 8; // Slack for sync and latch
	localparam int SETTLE = PWRUP_CYC - 2; // Coil surely off this long
	localparam int DONE = PWRUP_CYC + 4; // Settle surely over
	logic [WIDTH-1:0] lvl_q; // Shadow deviation level
	logic [WIDTH-1:0] trq_q; // Shadow torque level
	logic pol_q; // Shadow relay polarity
	int cnt_q; // Cycles since reset, saturating
	wire [WIDTH-1:0] err = (i_setpoint > i_process) ? i_setpoint - i_process
		: i_process - i_setpoint;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	// ====================
	// Shadows, taken at the edge where a write is acknowledged
	always @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			lvl_q <= `PDAO_DEVLVL_RST;
			trq_q <= `PDAO_TRQLVL_RST;
			pol_q <= `PDAO_POL_NC;
			cnt_q <= 0;
		end
		else
		begin
			if (cnt_q < DONE)
				cnt_q <= cnt_q + 1;
			if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack)
			begin
				if (i_wb_adr == `PDAO_DEVLVL_OFS)
					lvl_q <= i_wb_dat[WIDTH-1:0];
				if (i_wb_adr == `PDAO_TRQLVL_OFS)
					trq_q <= i_wb_dat[WIDTH-1:0];
				if (i_wb_adr == `PDAO_CTRL_OFS)
					pol_q <= i_wb_dat[`PDAO_CTRL_POL_BIT];
			end
		end
	end
	// ====================
	// Properties; pipeline slack lets a level settle before it is judged
	property p_ack_resp; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("bus answer missing");
	property p_ack_drop; o_wb_ack |=> !o_wb_ack; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
	property p_dev_on; (err > lvl_q) [*4] |-> o_pid_error_excess_flag; endproperty
	a_dev_on: assert property (p_dev_on) else $error("deviation flag low");
	property p_dev_off; (err < lvl_q) [*4] |-> !o_pid_error_excess_flag; endproperty
	a_dev_off: assert property (p_dev_off) else $error("deviation flag high");
	property p_dev_hold; (err == lvl_q) [*4] |-> $stable(o_pid_error_excess_flag); endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("deviation flag moved");
	property p_trq;
		($stable(i_torque) && $stable(trq_q)) [*3] |-> o_torque_excess_flag == (i_torque > trq_q);
	endproperty
	a_trq: assert property (p_trq) else $error("torque flag wrong");
	property p_alm_rise;
		$rose(i_fault && i_trip) && !o_fault_trip_flag |->
			(!o_fault_trip_flag) [*8] ##[1:AHI] o_fault_trip_flag;
	endproperty
	a_alm_rise: assert property (p_alm_rise) else $error("alarm delay wrong");
	property p_rly_settle; cnt_q < SETTLE |-> !o_relay_coil; endproperty
	a_rly_settle: assert property (p_rly_settle) else $error("coil before settle");
	property p_rly_mode;
		(cnt_q >= DONE && $stable(pol_q) && $stable(o_fault_trip_flag)) [*2] |->
			o_relay_coil == (pol_q ? o_fault_trip_flag : !o_fault_trip_flag);
	endproperty
	a_rly_mode: assert property (p_rly_mode) else $error("coil state wrong");
	c_alm: cover property ($rose(o_fault_trip_flag));
	c_dev: cover property ($rose(o_pid_error_excess_flag));
	c_open: cover property (pol_q && o_relay_coil);
endmodule

bind pdao_top pdao_checker #(.WIDTH(WIDTH), .ALM_DLY_CYC(ALM_DLY_CYC), .PWRUP_CYC(PWRUP_CYC))
	pdao_checker_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
	.o_wb_ack(o_wb_ack), .i_setpoint(i_setpoint), .i_process(i_process), .i_torque(i_torque),
	.i_fault(i_fault), .i_trip(i_trip), .o_pid_error_excess_flag(o_pid_error_excess_flag),
	.o_fault_trip_flag(o_fault_trip_flag), .o_torque_excess_flag(o_torque_excess_flag),
	.o_relay_coil(o_relay_coil));

/* File: tb/pdao_alarm_monitor.sv */
// Model of the external circuit on the collector and relay outputs.
// Assumes pull-ups on the collector lines and a contact closed by the coil.
`timescale 1ns/1ns
module pdao_alarm_monitor
(
	input wire i_oc1_n, // Collector line 1
	input wire i_oc2_n, // Collector line 2
	input wire i_relay_coil, // Coil drive
	output wire o_oc1_on, // Load on line 1 active
	output wire o_oc2_on, // Load on line 2 active
	output wire o_loop_closed // Alarm loop closed
);
	// A released collector is pulled up, so only a hard low counts as on
	assign o_oc1_on = (i_oc1_n === 1'b0);
	assign o_oc2_on = (i_oc2_n === 1'b0);
	// Loss of coil drive opens the loop, as a broken wire would
	assign o_loop_closed = (i_relay_coil === 1'b1);
endmodule

/* File: tb/pdao_top_tb_top.sv */
// Bench of the deviation, alarm and torque outputs, driven over Wishbone.
// Assumes short alarm and settle counts and the alarm monitor model.
`timescale 1ns/1ns
`include "pdao_regs.vh"
module pdao_top_tb_top;
	localparam int ALM = 10; // Shortened alarm delay
	localparam int PWR = 20; // Shortened settle time
	logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, flt = 1'b0, trp = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, rdat;
	logic [15:0] sp = 16'h0000, pv = 16'h0000, tq = 16'h0000;
	wire [31:0] o_dat;
	wire ack, dev, alm, trq, oc1_n, oc2_n, coil, irq, oc1_on, oc2_on, loop_ok;
	int num_errors = 0, n_tests = 0, cyc_cnt = 0;
	// Deviation cases: setpoint, measured value, expected flag
	logic [15:0] c_sp [5] = '{16'h0064, 16'h0064, 16'h0064, 16'h0061, 16'h006E};
	logic [15:0] c_pv [5] = '{16'h0068, 16'h0067, 16'h0065, 16'h0064, 16'h0064};
	logic c_ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	always #20 clk = ~clk;
	pdao_top #(.ALM_DLY_CYC(ALM), .PWRUP_CYC(PWR)) pdao_top_i (.i_ref_clk(clk), .i_srst(srst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack), .i_setpoint(sp), .i_process(pv),
		.i_torque(tq), .i_fault(flt), .i_trip(trp), .o_pid_error_excess_flag(dev),
		.o_fault_trip_flag(alm), .o_torque_excess_flag(trq), .o_oc1_n(oc1_n), .o_oc2_n(oc2_n),
		.o_relay_coil(coil), .o_irq(irq));
	pdao_alarm_monitor pdao_alarm_monitor_i (.i_oc1_n(oc1_n), .i_oc2_n(oc2_n),
		.i_relay_coil(coil), .o_oc1_on(oc1_on), .o_oc2_on(oc2_on), .o_loop_closed(loop_ok));
	// ====================
	// Shared tasks
	task test_done;
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rdat = o_dat;
		chk("ack", {31'h0000_0000, ack}, 32'h0000_0001);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic pid(input logic [15:0] s, input logic [15:0] p);
		@(posedge clk);
		sp <= s;
		pv <= p;
		wt(4);
	endtask
	// Fault and trip levels, then time for sync, delay and output update
	task automatic ft(input logic f, input logic t, input int n);
		@(posedge clk);
		flt <= f;
		trp <= t;
		wt(n);
	endtask
	// ====================
	// Cycle ceiling; the run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000)
		begin
			num_errors++;
			test_done;
		end
	end
	// ====================
	// Main sequence
	initial
	begin
		wt(2);
		srst <= 1'b0;
		wt(1);
		chk("coil", coil, 1'b0);
		wb(1'b0, `PDAO_DEVLVL_OFS, 32'h0000_0000);
		chk("devlvl", rdat, 32'h0000_0003);
		wb(1'b0, `PDAO_CTRL_OFS, 32'h0000_0000);
		chk("pol", rdat[0], 1'b0);
		wb(1'b0, `PDAO_ROUTE_OFS, 32'h0000_0000);
		chk("route", rdat, 32'h0005_0504);
		wb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", rdat, 32'h0000_0000);
		for (int k = 0; k < 5; k++)
		begin
			pid(c_sp[k], c_pv[k]);
			chk("dev", dev, c_ex[k]);
			chk("oc1", oc1_on, c_ex[k]);
		end
		wb(1'b1, `PDAO_DEVLVL_OFS, 32'h0000_0014);
		wt(4);
		chk("dev", dev, 1'b0);
		// Output 2 carries the torque code for this part
		wb(1'b1, `PDAO_ROUTE_OFS, 32'h0005_0704);
		@(posedge clk);
		tq <= 16'h0065;
		wt(3);
		chk("trq", trq, 1'b1);
		chk("oc2", oc2_on, 1'b1);
		@(posedge clk);
		tq <= 16'h0064;
		wt(3);
		chk("trq", trq, 1'b0);
		chk("oc2", oc2_on, 1'b0);
		chk("loop", loop_ok, 1'b1);
		wb(1'b1, `PDAO_ROUTE_OFS, 32'h0005_0505);
		ft(1'b1, 1'b0, ALM + 10);
		chk("alm", alm, 1'b0);
		wb(1'b1, `PDAO_IRQ_STAT_OFS, 32'h0000_000F);
		ft(1'b1, 1'b1, ALM - 2);
		chk("alm", alm, 1'b0);
		wt(12);
		chk("alm", alm, 1'b1);
		chk("loop", loop_ok, 1'b0);
		chk("oc", {oc1_on, oc2_on}, 2'b11);
		chk("irq", irq, 1'b0);
		wb(1'b1, `PDAO_IRQ_MASK_OFS, 32'h0000_0002);
		wt(2);
		chk("irq", irq, 1'b1);
		wb(1'b1, `PDAO_IRQ_STAT_OFS, 32'h0000_0002);
		wt(2);
		chk("irq", irq, 1'b0);
		// Trip gone but fault still there: alarm holds until a clear
		ft(1'b1, 1'b0, ALM + 8);
		chk("alm", alm, 1'b1);
		wb(1'b1, `PDAO_CTRL_OFS, 32'h0000_0002);
		wt(ALM + 8);
		chk("alm", alm, 1'b0);
		ft(1'b0, 1'b0, ALM + 8);
		chk("alm", alm, 1'b0);
		chk("loop", loop_ok, 1'b1);
		wb(1'b1, `PDAO_CTRL_OFS, 32'h0000_0001);
		wt(3);
		chk("coil", coil, 1'b0);
		ft(1'b1, 1'b1, ALM + 8);
		chk("coil", coil, 1'b1);
		ft(1'b0, 1'b0, ALM + 8);
		chk("coil", coil, 1'b0);
		test_done;
	end
endmodule
